// >>> hw/tsc_pkg.sv
// Constants and types of the touch ADC sequence control
package tsc_pkg;
  localparam int SYS_CLK_NS = 20;
  localparam int CONV_CLK_NS = 500;
  localparam int CONV_DIV = (CONV_CLK_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
  localparam int DIV_W = 5;
  localparam int CNT_W = 15;
  localparam logic [1:0] SEL_SETUP = 2'h0;
  localparam logic [1:0] SEL_SLAVE = 2'h1;
  localparam logic [1:0] SEL_MASTER = 2'h2;
  localparam logic [1:0] SEL_MODE = 2'h3;
  localparam int TMR_LSB = 0;
  localparam int POL_BIT = 3;
  localparam int FCD_LSB = 4;
  localparam int PM_LSB = 6;
  localparam int ACQ_LSB = 8;
  localparam int AVG_LSB = 10;
  localparam int MODE_LSB = 0;
  localparam int MODE_CH_LSB = 2;
  localparam logic [11:0] SETUP_RST = 12'h000;
  localparam logic [11:0] MASK_RST = 12'h000;
  localparam logic [11:0] MODE_RST = 12'h000;
  localparam logic [11:0] FIRST_CHAN_BIT = 12'h800;
  localparam logic [1:0] MODE_NONE = 2'h0;
  localparam logic [1:0] MODE_SINGLE = 2'h1;
  localparam logic [1:0] MODE_SLAVE = 2'h2;
  localparam logic [1:0] MODE_MASTER = 2'h3;
  localparam logic [1:0] PM_DOWN = 2'h0;
  localparam logic [1:0] PM_AUTO = 2'h1;
  localparam logic [1:0] PM_FULL = 2'h2;
  localparam logic [1:0] PM_REF_ON = 2'h3;
  localparam int FCD_CLKS_0 = 1;
  localparam int FCD_CLKS_1 = 256;
  localparam int FCD_CLKS_2 = 2048;
  localparam int FCD_CLKS_3 = 16384;
  localparam int TMR_CLKS_1 = 1024;
  localparam int TMR_CLKS_2 = 2048;
  localparam int TMR_CLKS_3 = 16384;
  localparam int ACQ_CLKS_0 = 4;
  localparam int ACQ_CLKS_1 = 8;
  localparam int ACQ_CLKS_2 = 16;
  localparam int ACQ_CLKS_3 = 32;
  localparam logic [3:0] LAST_CHAN = 4'ha;
  localparam logic [3:0] XY_LAST_CHAN = 4'h1;
  localparam logic [3:0] MASK_TOP = 4'hb;
  typedef enum logic [3:0] {
    ST_IDLE, ST_ARM, ST_REL, ST_PWR, ST_PICK,
    ST_ACQ, ST_CONV, ST_STORE, ST_POST, ST_TIMER
  } tsc_state_t;
endpackage

// >>> hw/tsc_down_counter.sv
// Loadable down counter that steps on a tick
`timescale 1ns/1ps
module tsc_down_counter #(
  parameter int W = 8
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic load,
  input wire logic [W-1:0] load_val,
  input wire logic tick,
  output logic count_zero
);
  logic [W-1:0] count;

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      count <= '0;
    end else if (load) begin
      count <= load_val;
    end else if (tick && count != '0) begin
      count <= count - W'(1);
    end
  end

  assign count_zero = (count == '0);
endmodule

// >>> hw/tsc_seq_ctrl.sv
// Conversion sequencing, power, data-available and touch interrupt
`timescale 1ns/1ps
module tsc_seq_ctrl import tsc_pkg::*; #(
  parameter int FCD1_CLKS = FCD_CLKS_1,
  parameter int FCD2_CLKS = FCD_CLKS_2,
  parameter int FCD3_CLKS = FCD_CLKS_3,
  parameter int TMR1_CLKS = TMR_CLKS_1,
  parameter int TMR2_CLKS = TMR_CLKS_2,
  parameter int TMR3_CLKS = TMR_CLKS_3
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic reg_wr,
  input wire logic [1:0] reg_sel,
  input wire logic [11:0] reg_wdata,
  input wire logic [1:0] rd_sel,
  output logic [11:0] rd_data,
  input wire logic result_read,
  input wire logic acquisition_inhibit_input,
  input wire logic touch_detect,
  input wire logic conv_done,
  input wire logic [11:0] conv_data,
  output logic conv_start,
  output logic [3:0] conv_channel,
  output logic sample_enable,
  output logic result_wr,
  output logic [3:0] result_chan,
  output logic [11:0] result_data,
  output logic adc_power_on,
  output logic ref_power_on,
  output logic data_available_n,
  output logic touch_interrupt_n
);
  logic [1:0] inh_sync;
  logic [1:0] touch_sync;
  logic inh_s;
  logic touch_s;
  logic [11:0] setup;
  logic [11:0] slave_mask;
  logic [11:0] master_mask;
  logic [11:0] mode_reg;
  logic [1:0] tmr_f;
  logic inhibit_polarity_bit;
  logic [1:0] first_conversion_delay;
  logic [1:0] power_policy_field;
  logic [1:0] sampling_time_field;
  logic [1:0] averaging_count_field;
  logic [1:0] mode_f;
  logic inhibit_active;
  tsc_state_t state;
  tsc_state_t next_state;
  logic conv_tick;
  logic cnt_zero;
  logic cnt_load;
  logic [CNT_W-1:0] cnt_val;
  logic seq_start;
  logic seq_end;
  logic mode_clear;
  logic busy;
  logic [3:0] chan;
  logic [3:0] rep;
  logic [15:0] acc;
  logic [11:0] seq_mask;
  logic xy_settled;
  logic [3:0] rep_last;
  logic chan_sel;

  function automatic logic [CNT_W-1:0] fcd_clks(input logic [1:0] code);
    unique case (code)
      2'h0: fcd_clks = CNT_W'(FCD_CLKS_0);
      2'h1: fcd_clks = CNT_W'(FCD1_CLKS);
      2'h2: fcd_clks = CNT_W'(FCD2_CLKS);
      2'h3: fcd_clks = CNT_W'(FCD3_CLKS);
    endcase
  endfunction

  function automatic logic [CNT_W-1:0] acq_clks(input logic [1:0] code);
    unique case (code)
      2'h0: acq_clks = CNT_W'(ACQ_CLKS_0);
      2'h1: acq_clks = CNT_W'(ACQ_CLKS_1);
      2'h2: acq_clks = CNT_W'(ACQ_CLKS_2);
      2'h3: acq_clks = CNT_W'(ACQ_CLKS_3);
    endcase
  endfunction

  function automatic logic [CNT_W-1:0] tmr_clks(input logic [1:0] code);
    unique case (code)
      2'h0: tmr_clks = '0;
      2'h1: tmr_clks = CNT_W'(TMR1_CLKS);
      2'h2: tmr_clks = CNT_W'(TMR2_CLKS);
      2'h3: tmr_clks = CNT_W'(TMR3_CLKS);
    endcase
  endfunction

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      inh_sync <= 2'h0;
      touch_sync <= 2'h0;
    end else begin
      inh_sync <= {inh_sync[0], acquisition_inhibit_input};
      touch_sync <= {touch_sync[0], touch_detect};
    end
  end
  assign inh_s = inh_sync[1];
  assign touch_s = touch_sync[1];

  assign tmr_f = setup[TMR_LSB +: 2];
  assign inhibit_polarity_bit = setup[POL_BIT];
  assign first_conversion_delay = setup[FCD_LSB +: 2];
  assign power_policy_field = setup[PM_LSB +: 2];
  assign sampling_time_field = setup[ACQ_LSB +: 2];
  assign averaging_count_field = setup[AVG_LSB +: 2];
  assign mode_f = mode_reg[MODE_LSB +: 2];
  assign inhibit_active = inhibit_polarity_bit ? inh_s : !inh_s;

  // One conversion clock tick every 500 ns drives every count
  tsc_down_counter #(.W(DIV_W)) u_prescale (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .load(conv_tick),
    .load_val(DIV_W'(CONV_DIV - 1)),
    .tick(1'b1),
    .count_zero(conv_tick)
  );

  // Sampling only advances while inhibit is inactive; delays never pause
  tsc_down_counter #(.W(CNT_W)) u_delay (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .load(cnt_load),
    .load_val(cnt_val),
    .tick(conv_tick && !(state == ST_ACQ && inhibit_active)),
    .count_zero(cnt_zero)
  );

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      setup <= SETUP_RST;
      slave_mask <= MASK_RST;
      master_mask <= MASK_RST;
    end else if (reg_wr) begin
      unique case (reg_sel)
        SEL_SETUP: setup <= reg_wdata;
        SEL_SLAVE: slave_mask <= reg_wdata;
        SEL_MASTER: master_mask <= reg_wdata;
        SEL_MODE: ;
      endcase
    end
  end

  // A host write in the same cycle beats the automatic clear
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      mode_reg <= MODE_RST;
    end else if (reg_wr && reg_sel == SEL_MODE) begin
      mode_reg <= reg_wdata;
    end else if (mode_clear) begin
      mode_reg[MODE_LSB +: 2] <= MODE_NONE;
    end
  end

  assign rep_last = averaging_count_field == 2'h0 ? 4'h0 :
                    averaging_count_field == 2'h1 ? 4'h3 :
                    averaging_count_field == 2'h2 ? 4'h7 : 4'hf;
  assign chan_sel = seq_mask[MASK_TOP - chan];
  assign seq_end = state == ST_POST && cnt_zero;

  always_comb begin
    next_state = state;
    cnt_load = 1'b0;
    cnt_val = fcd_clks(first_conversion_delay);
    mode_clear = 1'b0;
    unique case (state)
      ST_IDLE: begin
        if (power_policy_field != PM_DOWN) begin
          if (mode_f == MODE_SINGLE || mode_f == MODE_SLAVE) begin
            next_state = ST_PWR;
            cnt_load = 1'b1;
          end else if (mode_f == MODE_MASTER) begin
            next_state = ST_ARM;
          end
        end
      end
      ST_ARM: begin
        if (mode_f != MODE_MASTER || power_policy_field == PM_DOWN) begin
          next_state = ST_IDLE;
        end else if (touch_s) begin
          next_state = ST_PWR;
          cnt_load = 1'b1;
        end
      end
      ST_REL: begin
        if (mode_f != MODE_MASTER) begin
          next_state = ST_IDLE;
        end else if (!touch_s) begin
          next_state = ST_ARM;
        end
      end
      ST_PWR: begin
        if (cnt_zero) begin
          next_state = ST_PICK;
        end
      end
      ST_PICK: begin
        if (chan > LAST_CHAN) begin
          next_state = ST_POST;
          cnt_load = 1'b1;
        end else if (chan_sel && chan <= XY_LAST_CHAN && !xy_settled) begin
          next_state = ST_PWR;
          cnt_load = 1'b1;
        end else if (chan_sel) begin
          next_state = ST_ACQ;
          cnt_load = 1'b1;
          cnt_val = acq_clks(sampling_time_field);
        end
      end
      ST_ACQ: begin
        if (cnt_zero) begin
          next_state = ST_CONV;
        end
      end
      ST_CONV: begin
        if (conv_done && rep == rep_last) begin
          next_state = ST_STORE;
        end else if (conv_done) begin
          next_state = ST_ACQ;
          cnt_load = 1'b1;
          cnt_val = acq_clks(sampling_time_field);
        end
      end
      ST_STORE: begin
        next_state = ST_PICK;
      end
      ST_POST: begin
        if (cnt_zero) begin
          cnt_val = tmr_clks(tmr_f);
          if (mode_f == MODE_MASTER && !touch_s) begin
            next_state = ST_ARM;
          end else if (tmr_f != 2'h0) begin
            next_state = ST_TIMER;
            cnt_load = 1'b1;
          end else if (mode_f == MODE_MASTER) begin
            next_state = ST_REL;
          end else begin
            next_state = ST_IDLE;
            mode_clear = 1'b1;
          end
        end
      end
      ST_TIMER: begin
        if (mode_f == MODE_MASTER && !touch_s) begin
          next_state = ST_ARM;
        end else if (mode_f == MODE_NONE || power_policy_field == PM_DOWN) begin
          next_state = ST_IDLE;
        end else if (cnt_zero) begin
          next_state = ST_PWR;
          cnt_load = 1'b1;
        end
      end
    endcase
  end

  assign seq_start = next_state == ST_PWR &&
                     (state == ST_IDLE || state == ST_ARM || state == ST_TIMER);
  assign busy = !(state == ST_IDLE || state == ST_ARM ||
                  state == ST_REL || state == ST_TIMER);

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      chan <= 4'h0;
      rep <= 4'h0;
      acc <= 16'h0000;
      seq_mask <= MASK_RST;
      xy_settled <= 1'b0;
    end else if (seq_start) begin
      chan <= 4'h0;
      rep <= 4'h0;
      acc <= 16'h0000;
      xy_settled <= 1'b0;
      unique case (mode_f)
        MODE_SINGLE: seq_mask <= FIRST_CHAN_BIT >> mode_reg[MODE_CH_LSB +: 4];
        MODE_SLAVE: seq_mask <= slave_mask;
        MODE_MASTER: seq_mask <= master_mask;
        MODE_NONE: seq_mask <= MASK_RST;
      endcase
    end else begin
      if (state == ST_PWR && cnt_zero) begin
        xy_settled <= 1'b1;
      end
      if (state == ST_PICK && chan <= LAST_CHAN && !chan_sel) begin
        chan <= chan + 4'h1;
      end
      if (state == ST_CONV && conv_done) begin
        acc <= acc + {4'h0, conv_data};
        rep <= rep + 4'h1;
      end
      if (state == ST_STORE) begin
        chan <= chan + 4'h1;
        rep <= 4'h0;
        acc <= 16'h0000;
        xy_settled <= 1'b0;
      end
    end
  end

  // Only the mean reaches the result port
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      result_wr <= 1'b0;
      result_chan <= 4'h0;
      result_data <= 12'h000;
      conv_start <= 1'b0;
      conv_channel <= 4'h0;
      sample_enable <= 1'b0;
    end else begin
      result_wr <= state == ST_STORE;
      if (state == ST_STORE) begin
        result_chan <= chan;
        result_data <= 12'(acc >> (averaging_count_field == 2'h0 ? 0 :
                       32'(averaging_count_field) + 1));
      end
      conv_start <= next_state == ST_CONV && state != ST_CONV;
      conv_channel <= chan;
      sample_enable <= next_state == ST_ACQ && !inhibit_active;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      adc_power_on <= 1'b0;
      ref_power_on <= 1'b0;
    end else begin
      adc_power_on <= power_policy_field == PM_FULL ||
                      (power_policy_field != PM_DOWN && busy);
      ref_power_on <= power_policy_field == PM_FULL ||
                      power_policy_field == PM_REF_ON ||
                      (power_policy_field == PM_AUTO && busy);
    end
  end

  // Fresh results win over a read landing in the same cycle
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      data_available_n <= 1'b1;
    end else if (seq_end) begin
      data_available_n <= 1'b0;
    end else if (result_read) begin
      data_available_n <= 1'b1;
    end else if (seq_start) begin
      data_available_n <= 1'b1;
    end
  end

  // Detection is frozen while converting, so a release waits for idle
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      touch_interrupt_n <= 1'b1;
    end else if (!busy) begin
      touch_interrupt_n <= !touch_s;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      rd_data <= 12'h000;
    end else begin
      unique case (rd_sel)
        SEL_SETUP: rd_data <= setup;
        SEL_SLAVE: rd_data <= slave_mask;
        SEL_MASTER: rd_data <= master_mask;
        SEL_MODE: rd_data <= mode_reg;
      endcase
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  sequence s_seq_end;
    state == ST_POST && cnt_zero;
  endsequence

  sequence s_timer_fire;
    state == ST_TIMER && cnt_zero && (touch_s || mode_f != MODE_MASTER) &&
      mode_f != MODE_NONE && power_policy_field != PM_DOWN;
  endsequence

  a_inhibit_blocks: assert property (
    (state == ST_ACQ && inhibit_active && !cnt_zero) |=>
      (!conv_start && !cnt_zero && state == ST_ACQ)
  ) else $error("conversion started while inhibited");

  a_pm_off_idle: assert property (
    (power_policy_field == PM_DOWN && state == ST_IDLE) |=> state == ST_IDLE
  ) else $error("sequence left idle with power off");

  a_dav_on_done: assert property (
    s_seq_end |=> !data_available_n
  ) else $error("data-available not low after sequence");

  a_dav_read: assert property (
    (result_read && !seq_end) |=> data_available_n
  ) else $error("data-available not released by read");

  a_dav_timer: assert property (
    s_timer_fire |=> (data_available_n && state == ST_PWR)
  ) else $error("timer restart did not release data-available");

  a_pen_frozen: assert property (
    (busy && $past(busy)) |-> $stable(touch_interrupt_n)
  ) else $error("touch interrupt changed while converting");

  a_pen_release: assert property (
    (!busy && !touch_s) [*2] |=> touch_interrupt_n
  ) else $error("touch interrupt not released while idle");

  a_slave_clear: assert property (
    (s_seq_end ##0 (tmr_f == 2'h0 && mode_f == MODE_SLAVE &&
      !(reg_wr && reg_sel == SEL_MODE))) |=> (mode_f == MODE_NONE && state == ST_IDLE)
  ) else $error("mode bits not cleared after single sequence");

  a_master_arm: assert property (
    (state == ST_ARM && touch_s && mode_f == MODE_MASTER &&
      power_policy_field != PM_DOWN) |=> ##[0:2] state == ST_PWR
  ) else $error("touch did not start master sequence");

  a_avg_store: assert property (
    (state == ST_CONV && conv_done && rep == rep_last) |=> ##1 result_wr
  ) else $error("averaged result not stored");
endmodule

// >>> sim/tsc_conv_model.sv
// Behavioural converter answering conversion starts with random latency and data
`timescale 1ns/1ps
module tsc_conv_model (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic conv_start,
  output logic conv_done = 1'b0,
  output logic [11:0] conv_data = 12'h000
);
  logic busy = 1'b0;
  int wait_n = 0;
  always @(posedge sys_clk) begin
    conv_done <= 1'b0;
    // Data is only valid with the done pulse, so it toggles in between
    conv_data <= ~conv_data;
    if (!nrst) begin
      busy <= 1'b0;
    end else if (conv_start) begin
      busy <= 1'b1;
      wait_n <= 1 + $urandom % 6;
    end else if (busy) begin
      if (wait_n <= 1) begin
        busy <= 1'b0;
        conv_done <= 1'b1;
        conv_data <= 12'($urandom);
      end else begin
        wait_n <= wait_n - 1;
      end
    end
  end
endmodule

// >>> sim/tb.sv
// Self-checking bench of the sequence control block
`timescale 1ns/1ps
module tb import tsc_pkg::*;;
  logic sys_clk = 0, nrst = 0, reg_wr = 0, result_read = 0;
  // Inactive level for the default active-low inhibit polarity
  logic acquisition_inhibit_input = 1, touch_detect = 0;
  logic [1:0] reg_sel = 0, rd_sel = 0;
  logic [11:0] reg_wdata = 0, rd_data, result_data, conv_data, m, d;
  logic [3:0] conv_channel, result_chan;
  logic conv_start, conv_done, sample_enable, result_wr, adc_power_on, ref_power_on;
  logic data_available_n, touch_interrupt_n;
  int miscompares = 0, n_tests = 0, exp_q[$], sum = 0, ncv = 0, se_len = 0, n_starts = 0;
  int avg_code = 0, acq_code = 0, k = 0;
  bit chk_acq = 0;
  always #10 sys_clk = ~sys_clk;
  tsc_seq_ctrl #(.FCD1_CLKS(3), .FCD2_CLKS(4), .FCD3_CLKS(5), .TMR1_CLKS(6))
    tsc_seq_ctrl_i (.sys_clk, .nrst, .reg_wr, .reg_sel, .reg_wdata, .rd_sel,
    .rd_data, .result_read, .acquisition_inhibit_input, .touch_detect, .conv_done,
    .conv_data, .conv_start, .conv_channel, .sample_enable, .result_wr, .result_chan,
    .result_data, .adc_power_on, .ref_power_on, .data_available_n, .touch_interrupt_n);
  tsc_conv_model tsc_conv_model_i (.sys_clk, .nrst, .conv_start, .conv_done, .conv_data);

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic wr(input logic [1:0] s, input logic [11:0] v);
    step(1);
    reg_wr = 1;
    reg_sel = s;
    reg_wdata = v;
    step(1);
    reg_wr = 0;
  endtask
  task automatic rd(input logic [1:0] s, output logic [11:0] v);
    rd_sel = s;
    step(2);
    v = rd_data;
  endtask
  function automatic logic sig(input int w);
    case (w)
      0: return data_available_n;
      1: return sample_enable;
      default: return conv_start;
    endcase
  endfunction
  // Every wait is bounded; running out ends the run as a failure
  task automatic wait_sig(input int w, input logic v, input int bound, output int took);
    took = 0;
    while (sig(w) !== v && took < bound) begin
      step(1);
      took++;
    end
    if (sig(w) !== v) begin
      miscompares++;
      $display("Error signal %0d expected %0b seen %0b", w, v, sig(w));
      end_of_test();
    end
  endtask
  task automatic set_q(input logic [11:0] mk);
    exp_q.delete();
    for (int c = 0; c < 11; c++) if (mk[11 - c]) exp_q.push_back(c);
  endtask
  task automatic done_read();
    chk("queue_left", exp_q.size(), 0);
    rd(SEL_MODE, d);
    chk("mode_after", d[1:0], MODE_NONE);
    result_read = 1;
    step(1);
    result_read = 0;
    chk("dav_after_read", data_available_n, 1);
  endtask

  // Host side monitor: averages, channel order, sampling length
  always @(posedge sys_clk) begin
    if (conv_start === 1'b1) begin
      n_starts++;
      chk("conv_channel", conv_channel, exp_q.size() > 0 ? exp_q[0] : 15);
    end
    if (result_wr === 1'b1) begin
      chk("result_chan", result_chan, exp_q.size() > 0 ? exp_q.pop_front() : 15);
      chk("conversions", ncv, 1 << (avg_code == 0 ? 0 : avg_code + 1));
      chk("result_data", result_data, sum >> (avg_code == 0 ? 0 : avg_code + 1));
      sum = 0;
      ncv = 0;
    end
    if (conv_done) begin
      sum += conv_data;
      ncv++;
    end
    if (sample_enable === 1'b1) se_len++;
    else if (se_len > 0) begin
      if (chk_acq) chk("sample_time", se_len >= ((4 << acq_code) - 1) * 25 &&
        se_len <= (4 << acq_code) * 25 + 2, 1);
      se_len = 0;
    end
  end

  initial begin
    void'($urandom(32'hb015));
    repeat (2) @(posedge sys_clk);
    #1 nrst = 1;
    chk("dav_reset", data_available_n, 1);
    chk("irq_reset", touch_interrupt_n, 1);
    for (int s = 0; s < 4; s++) begin
      rd(2'(s), d);
      chk("reg_reset", d, 12'h000);
    end
    $display("test reset done");
    // Power code 00 blocks a requested slave sequence
    set_q(12'h040);
    wr(SEL_SLAVE, 12'h040);
    wr(SEL_MODE, {10'h000, MODE_SLAVE});
    n_starts = 0;
    step(300);
    chk("starts_pm00", n_starts, 0);
    chk("adc_pm00", adc_power_on, 0);
    $display("test power down done");
    // Power code 01 with delay code 10 releases the pending sequence
    chk_acq = 1;
    wr(SEL_SETUP, 12'h060);
    wait_sig(2, 1, 400, k);
    chk("first_delay", k >= 150 && k <= 215, 1);
    wait_sig(0, 0, 2000, k);
    // Power flops follow busy one edge after data-available falls
    step(1);
    chk("adc_idle_01", adc_power_on, 0);
    chk("ref_idle_01", ref_power_on, 0);
    done_read();
    $display("test first delay done");
    // Single mode converts the channel named in the mode register
    set_q(12'h100);
    wr(SEL_MODE, {6'h00, 4'h3, MODE_SINGLE});
    wait_sig(0, 0, 2000, k);
    chk("dav_single", data_available_n, 0);
    done_read();
    $display("test single mode done");
    // Every averaging and sampling code, random channel sets and delays
    for (int i = 0; i < 4; i++) begin
      avg_code = i;
      acq_code = 3 - i;
      m = (12'($urandom) & 12'hcce) | 12'h100;
      set_q(m);
      wr(SEL_SLAVE, m);
      wr(SEL_SETUP, {2'(i), 2'(3 - i), 2'b01, 2'($urandom), 4'h0});
      rd(SEL_SLAVE, d);
      chk("mask_readback", d, m);
      wr(SEL_MODE, {10'h000, MODE_SLAVE});
      wait_sig(0, 0, 40000, k);
      chk("dav_end", data_available_n, 0);
      done_read();
    end
    $display("test averaging done");
    // Inhibit of either polarity holds sampling off
    avg_code = 0;
    acq_code = 3;
    chk_acq = 0;
    for (int p = 0; p < 2; p++) begin
      acquisition_inhibit_input = !p;
      wr(SEL_SETUP, {6'b001101, 2'b00, 1'(p), 3'b000});
      set_q(12'h040);
      wr(SEL_SLAVE, 12'h040);
      wr(SEL_MODE, {10'h000, MODE_SLAVE});
      wait_sig(1, 1, 400, k);
      acquisition_inhibit_input = p;
      n_starts = 0;
      step(1200);
      chk("starts_inhibit", n_starts, 0);
      acquisition_inhibit_input = !p;
      wait_sig(0, 0, 3000, k);
      done_read();
    end
    acquisition_inhibit_input = 1;
    $display("test inhibit done");
    // Timer repeat with full power; the host leaves results unread
    acq_code = 0;
    chk_acq = 1;
    wr(SEL_SETUP, 12'h081);
    set_q(12'h400);
    exp_q.push_back(1);
    wr(SEL_SLAVE, 12'h400);
    wr(SEL_MODE, {10'h000, MODE_SLAVE});
    wait_sig(0, 0, 3000, k);
    chk("adc_full", adc_power_on, 1);
    chk("ref_full", ref_power_on, 1);
    wait_sig(0, 1, 400, k);
    chk("timer_gap", k >= 100 && k <= 200, 1);
    wr(SEL_SETUP, 12'h080);
    wait_sig(0, 0, 3000, k);
    done_read();
    $display("test timer done");
    // Master mode: wake on touch, interrupt held through conversion
    wr(SEL_SETUP, 12'h0c0);
    set_q(12'h800);
    wr(SEL_MASTER, 12'h800);
    wr(SEL_MODE, {10'h000, MODE_MASTER});
    n_starts = 0;
    step(200);
    chk("starts_no_touch", n_starts, 0);
    chk("adc_idle_11", adc_power_on, 0);
    chk("ref_idle_11", ref_power_on, 1);
    chk("irq_idle", touch_interrupt_n, 1);
    touch_detect = 1;
    step(6);
    chk("irq_touch", touch_interrupt_n, 0);
    wait_sig(1, 1, 800, k);
    touch_detect = 0;
    step(10);
    chk("irq_busy", touch_interrupt_n, 0);
    wait_sig(0, 0, 3000, k);
    step(6);
    chk("irq_idle_again", touch_interrupt_n, 1);
    chk("queue_master", exp_q.size(), 0);
    $display("test master done");
    end_of_test();
  end
endmodule
